// ==== shared/sdwp_pkg.sv ====
// constants shared by the serial converter write port
// assumes a sixteen bit frame, most significant bit first
package sdwp_pkg;

   // -------------------------------------------------------------
   // frame layout
   // -------------------------------------------------------------
   localparam int unsigned FRAME_BITS = 16;
   localparam int unsigned CNT_W      = 5;
   localparam int unsigned MODE_W     = 2;
   localparam int unsigned CODE_W     = 12;
   localparam int unsigned MODE_HI    = 13;
   localparam int unsigned MODE_LO    = 12;
   localparam int unsigned CODE_MSB   = 11;
   localparam int unsigned CODE_LSB   = 0;
   localparam int unsigned WORD_W     = MODE_W + CODE_W;

   localparam logic [CNT_W-1:0] CNT_LAST = 5'h0f;
   localparam logic [CNT_W-1:0] CNT_DONE = 5'h10;
   localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

   // -------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------
   localparam logic [FRAME_BITS-1:0] SHIFT_RST = 16'h0000;
   localparam logic [CODE_W-1:0]     CODE_RST  = 12'h000;
   localparam logic [7:0]            CNT8_RST  = 8'h00;

   // -------------------------------------------------------------
   // operating modes
   // -------------------------------------------------------------
   typedef enum logic [MODE_W-1:0] {
      SDWP_MODE_NORMAL = 2'h0,
      SDWP_MODE_PD_1K  = 2'h1,
      SDWP_MODE_PD_100K= 2'h2,
      SDWP_MODE_PD_HIZ = 2'h3
   } sdwp_mode_e;

   // apply sequencer, gray coded along idle, apply, ack
   typedef enum logic [1:0] {
      SDWP_ST_IDLE  = 2'h0,
      SDWP_ST_APPLY = 2'h1,
      SDWP_ST_ACK   = 2'h3
   } sdwp_state_e;

endpackage

// ==== rtl/sdwp_buf.sv ====
// two entry buffer with valid and ready on both sides
// assumes one clock and a synchronous active low reset
`timescale 1ns/10ps
`default_nettype none
module sdwp_buf #(
   parameter int unsigned W     = 14,
   parameter int unsigned DEPTH = 2
) (
   input  wire logic         clock_i,
   input  wire logic         rst_n_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW:0] FILL_FULL = (PW+1)'(DEPTH);

   logic [W-1:0]  mem_q [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [PW:0]   fill_q;
   logic          push;
   logic          pop;

   function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
      nxt = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction

   assign in_ready_o  = (fill_q != FILL_FULL);
   assign out_valid_o = (fill_q != '0);
   assign out_data_o  = mem_q[rd_q];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_ff @(posedge clock_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         wr_q   <= '0;
         rd_q   <= '0;
         fill_q <= '0;
      end else begin
         if (push) begin
            wr_q <= nxt(wr_q);
         end
         if (pop) begin
            rd_q <= nxt(rd_q);
         end
         if (push && !pop) begin
            fill_q <= fill_q + 1'b1;
         end else if (pop && !push) begin
            fill_q <= fill_q - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== rtl/sdwp_top.sv ====
// serial write port of a twelve bit voltage output converter
// assumes the host owns the serial clock, which may stop between frames,
// and that clock_i is a free running system clock unrelated to it
//
// Function
// - frame select low starts a frame; data sampled on each falling serial edge
// - sixteenth falling edge takes last bit and executes the frame
// - frame select rising early clears the shift register and discards the frame
// - first two frame bits are ignored, next two select the mode
// - mode 00 normal, 01 1k pull-down, 10 100k pull-down, 11 high impedance
// - code is straight binary 0 to 4095, output is supply times code/4096
// - frame bits arrive most significant first
// - reset clears the converter code to zero, output held at zero volts
// - power-down entry or exit loads the converter code carried by that frame
`timescale 1ns/10ps
`default_nettype none
module sdwp_top
   import sdwp_pkg::*;
#(
   parameter int unsigned BUF_DEPTH = 2
) (
   input  wire logic                       clock_i,
   input  wire logic                       rst_n_i,
   input  wire logic                       sclk_i,
   input  wire logic                       frame_n_i,
   input  wire logic                       sdata_i,
   input  wire logic                       conv_ready_i,
   output logic [sdwp_pkg::CODE_W-1:0]     code_o,
   output logic [sdwp_pkg::MODE_W-1:0]     mode_o,
   output logic                            amp_on_o,
   output logic                            pulldown_1k_o,
   output logic                            pulldown_100k_o,
   output logic                            out_hiz_o,
   output logic                            update_o,
   output logic                            overrun_o,
   output logic                            frame_busy_o,
   output logic [7:0]                      frame_count_o
);
   import sdwp_pkg::*;

   // -------------------------------------------------------------
   // field decode helpers
   // -------------------------------------------------------------
   function automatic sdwp_mode_e word_mode(input logic [WORD_W-1:0] w);
      word_mode = sdwp_mode_e'(w[WORD_W-1 -: MODE_W]);
   endfunction

   function automatic logic [CODE_W-1:0] word_code(input logic [WORD_W-1:0] w);
      word_code = w[CODE_W-1:0];
   endfunction

   // -------------------------------------------------------------
   // link domain: falling serial edges
   // -------------------------------------------------------------
   // frame select high acts as the asynchronous clear of shift register, counter and done flag,
   // since the serial clock may never tick again after an abort
   logic [FRAME_BITS-1:0] shift_q;
   logic [CNT_W-1:0]      bits_q;
   logic [WORD_W-1:0]     link_word_q;
   logic                  link_done_q;
   logic [FRAME_BITS-1:0] shift_d;

   assign shift_d = {shift_q[FRAME_BITS-2:0], sdata_i};

   always_ff @(negedge sclk_i or posedge frame_n_i) begin
      if (frame_n_i) begin
         shift_q <= SHIFT_RST;
      end else if (bits_q != CNT_DONE) begin
         shift_q <= shift_d;
      end
   end

   // edges beyond the sixteenth are ignored until frame select rises
   always_ff @(negedge sclk_i or posedge frame_n_i) begin
      if (frame_n_i) begin
         bits_q <= CNT_ZERO;
      end else if (bits_q != CNT_DONE) begin
         bits_q <= bits_q + 1'b1;
      end
   end

   // the word stays put between frames; the system side reads it only
   // after the done flag has crossed, long before the next frame
   always_ff @(negedge sclk_i) begin
      if (!frame_n_i && bits_q == CNT_LAST) begin
         link_word_q <= shift_d[MODE_HI:CODE_LSB];
      end
   end

   // done level, cleared with the frame like the counter, so its value is
   // always known; limitation: frame select must stay high for a few
   // system clocks between frames, or the next frame is not seen
   always_ff @(negedge sclk_i or posedge frame_n_i) begin
      if (frame_n_i) begin
         link_done_q <= 1'b0;
      end else if (bits_q == CNT_LAST) begin
         link_done_q <= 1'b1;
      end
   end

   // -------------------------------------------------------------
   // crossing into the system domain
   // -------------------------------------------------------------
   logic done_s1_q;
   logic done_s2_q;
   logic done_s3_q;
   logic frm_s1_q;
   logic frm_s2_q;
   logic frame_event;

   always_ff @(posedge clock_i) begin
      done_s1_q <= link_done_q;
      done_s2_q <= done_s1_q;
      frm_s1_q  <= frame_n_i;
      frm_s2_q  <= frm_s1_q;
   end

   // reset value equals the idle level of the done flag, so no false
   // rising edge follows reset
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         done_s3_q <= 1'b0;
      end else begin
         done_s3_q <= done_s2_q;
      end
   end

   // the synchroniser has no reset; events are held off in the first
   // cycle after reset, while it may still show its power-up value
   logic seeded_q;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         seeded_q <= 1'b0;
      end else begin
         seeded_q <= 1'b1;
      end
   end

   assign frame_event = seeded_q && done_s2_q && !done_s3_q;

   // -------------------------------------------------------------
   // pending word and buffer feed
   // -------------------------------------------------------------
   logic              pend_q;
   logic [WORD_W-1:0] pend_word_q;
   logic              buf_in_ready;
   logic              buf_out_valid;
   logic              buf_out_ready;
   logic [WORD_W-1:0] buf_out_data;
   logic              push;

   assign push = pend_q && buf_in_ready;

   // a held word waits here while the buffer is full; a second frame
   // arriving meanwhile replaces it and flags the loss
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         pend_q <= 1'b0;
      end else if (frame_event) begin
         pend_q <= 1'b1;
      end else if (push) begin
         pend_q <= 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         pend_word_q <= {MODE_W'(SDWP_MODE_NORMAL), CODE_RST};
      end else if (frame_event) begin
         pend_word_q <= link_word_q;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         overrun_o <= 1'b0;
      end else if (frame_event && pend_q && !buf_in_ready) begin
         overrun_o <= 1'b1;
      end
   end

   sdwp_buf #(
      .W     (WORD_W),
      .DEPTH (BUF_DEPTH)
   ) u_buf (
      .clock_i     (clock_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (pend_q),
      .in_ready_o  (buf_in_ready),
      .in_data_i   (pend_word_q),
      .out_valid_o (buf_out_valid),
      .out_ready_i (buf_out_ready),
      .out_data_o  (buf_out_data)
   );

   // -------------------------------------------------------------
   // apply sequencer
   // -------------------------------------------------------------
   sdwp_state_e       state_q;
   logic [WORD_W-1:0] apply_word_q;

   assign buf_out_ready = (state_q == SDWP_ST_IDLE) && conv_ready_i;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         state_q <= SDWP_ST_IDLE;
      end else begin
         unique case (state_q)
            SDWP_ST_IDLE: begin
               if (buf_out_valid && conv_ready_i) begin
                  state_q <= SDWP_ST_APPLY;
               end
            end
            SDWP_ST_APPLY: begin
               state_q <= SDWP_ST_ACK;
            end
            SDWP_ST_ACK: begin
               state_q <= SDWP_ST_IDLE;
            end
            default: begin
               state_q <= SDWP_ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         apply_word_q <= {MODE_W'(SDWP_MODE_NORMAL), CODE_RST};
      end else if (buf_out_ready && buf_out_valid) begin
         apply_word_q <= buf_out_data;
      end
   end

   // -------------------------------------------------------------
   // converter register and mode
   // -------------------------------------------------------------
   // the code is written by every frame, whatever its mode, so leaving
   // power-down applies the code carried by the frame that leaves it
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         code_o <= CODE_RST;
      end else if (state_q == SDWP_ST_APPLY) begin
         code_o <= word_code(apply_word_q);
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         mode_o <= MODE_W'(SDWP_MODE_NORMAL);
      end else if (state_q == SDWP_ST_APPLY) begin
         mode_o <= MODE_W'(word_mode(apply_word_q));
      end
   end

   // analog controls follow the mode chosen by the same apply step
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         amp_on_o        <= 1'b1;
         pulldown_1k_o   <= 1'b0;
         pulldown_100k_o <= 1'b0;
         out_hiz_o       <= 1'b0;
      end else if (state_q == SDWP_ST_APPLY) begin
         amp_on_o        <= (word_mode(apply_word_q) == SDWP_MODE_NORMAL);
         pulldown_1k_o   <= (word_mode(apply_word_q) == SDWP_MODE_PD_1K);
         pulldown_100k_o <= (word_mode(apply_word_q) == SDWP_MODE_PD_100K);
         out_hiz_o       <= (word_mode(apply_word_q) == SDWP_MODE_PD_HIZ);
      end
   end

   // -------------------------------------------------------------
   // status
   // -------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         update_o <= 1'b0;
      end else begin
         update_o <= (state_q == SDWP_ST_APPLY);
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         frame_count_o <= CNT8_RST;
      end else if (state_q == SDWP_ST_APPLY) begin
         frame_count_o <= frame_count_o + 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         frame_busy_o <= 1'b0;
      end else begin
         frame_busy_o <= !frm_s2_q;
      end
   end

endmodule
`default_nettype wire

// ==== sim/sdwp_host.sv ====
// serial host model driving the three wire write link
// assumes the bench calls send starting on a clock_i falling edge
`timescale 1ns/10ps
`default_nettype none
module sdwp_host (
   output logic sclk_o,
   output logic frame_n_o,
   output logic sdata_o
);
   // frame select rises just after time zero, so the link logic sees a
   // real clearing edge once every process is waiting
   initial begin
      sclk_o    = 1'b0;
      sdata_o   = 1'b0;
      #1;
      frame_n_o = 1'b1;
   end

   // hold leaves frame select low for a second byte
   task automatic send(input logic [15:0] w, input int n, input logic hold);
      int i;
      #3;
      frame_n_o = 1'b0;
      #40;
      for (i = 0; i < n; i++) begin
         sclk_o  = 1'b1;
         sdata_o = w[15-i];
         #80;
         sclk_o = 1'b0;
         #80;
      end
      if (!hold) begin
         // clock stands still, data no longer shows the last bit
         frame_n_o = 1'b1;
         sdata_o   = ~sdata_o;
         #1000;
      end
   endtask
endmodule
`default_nettype wire

// ==== sim/sdwp_top_assertions.sv ====
// timing checks on the converter write port outputs
// assumes clock_i and the synchronous active low reset of the top
`timescale 1ns/10ps
`default_nettype none
module sdwp_chk
   import sdwp_pkg::*;
(
   input wire logic                   clock_i,
   input wire logic                   rst_n_i,
   input wire logic                   sclk_i,
   input wire logic                   frame_n_i,
   input wire logic                   sdata_i,
   input wire logic                   conv_ready_i,
   input wire logic [sdwp_pkg::CODE_W-1:0] code_o,
   input wire logic [sdwp_pkg::MODE_W-1:0] mode_o,
   input wire logic                   amp_on_o,
   input wire logic                   pulldown_1k_o,
   input wire logic                   pulldown_100k_o,
   input wire logic                   out_hiz_o,
   input wire logic                   update_o,
   input wire logic                   overrun_o,
   input wire logic                   frame_busy_o,
   input wire logic [7:0]             frame_count_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   reset_clear_a: assert property ($rose(rst_n_i) |-> code_o == CODE_RST && mode_o == 2'h0
      && frame_count_o == 8'h00) else $error("outputs not cleared by reset");
   code_update_a: assert property ($changed(code_o) |-> update_o)
      else $error("code changed without update pulse");
   mode_update_a: assert property ($changed(mode_o) |-> update_o)
      else $error("mode changed without update pulse");
   pulse_once_a: assert property (update_o |=> !update_o)
      else $error("update longer than one cycle");
   count_step_a: assert property (update_o |-> frame_count_o == $past(frame_count_o) + 8'h01)
      else $error("frame count did not step");
   count_only_a: assert property ($changed(frame_count_o) |-> update_o)
      else $error("frame count moved without update");
   amp_mode_a: assert property (amp_on_o == (mode_o == SDWP_MODE_NORMAL))
      else $error("amplifier enable does not match mode");
   pd_kind_a: assert property (pulldown_1k_o == (mode_o == SDWP_MODE_PD_1K)
      && pulldown_100k_o == (mode_o == SDWP_MODE_PD_100K) && out_hiz_o == (mode_o == SDWP_MODE_PD_HIZ))
      else $error("power-down kind does not match mode");
   busy_seen_a: assert property ($fell(frame_n_i) |-> ##[1:4] frame_busy_o)
      else $error("frame start not seen");

   cover property (update_o && mode_o == SDWP_MODE_PD_HIZ);
   cover property ($rose(overrun_o));
   cover property (update_o && code_o == 12'hfff);
endmodule

bind sdwp_top sdwp_chk u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i),
   .frame_n_i(frame_n_i), .sdata_i(sdata_i), .conv_ready_i(conv_ready_i), .code_o(code_o),
   .mode_o(mode_o), .amp_on_o(amp_on_o), .pulldown_1k_o(pulldown_1k_o),
   .pulldown_100k_o(pulldown_100k_o), .out_hiz_o(out_hiz_o), .update_o(update_o),
   .overrun_o(overrun_o), .frame_busy_o(frame_busy_o), .frame_count_o(frame_count_o));
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench for the converter write port
// assumes the host model owns the link and the bench owns clock_i
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import sdwp_pkg::*;
   logic              clock_i, rst_n_i, conv_ready_i, sclk, frame_n, sdata;
   logic              amp_on, pd1k, pd100k, hiz, update, overrun, busy;
   logic [CODE_W-1:0] code;
   logic [MODE_W-1:0] mode;
   logic [7:0]        count, exp_cnt;
   int                failures, samples_checked, cycles;

   sdwp_host u_host (.sclk_o(sclk), .frame_n_o(frame_n), .sdata_o(sdata));
   sdwp_top #(.BUF_DEPTH(2)) u_sdwp_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .sclk_i(sclk),
      .frame_n_i(frame_n), .sdata_i(sdata), .conv_ready_i(conv_ready_i), .code_o(code),
      .mode_o(mode), .amp_on_o(amp_on), .pulldown_1k_o(pd1k), .pulldown_100k_o(pd100k),
      .out_hiz_o(hiz), .update_o(update), .overrun_o(overrun), .frame_busy_o(busy),
      .frame_count_o(count));

   always #5 clock_i = ~clock_i;

   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   task automatic end_sim();
      if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         end_sim();
      end
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         failures++;
      end
   endtask

   task automatic wait_upd();
      int n;
      n = 0;
      while (update !== 1'b1 && n < 600) begin
         @(negedge clock_i);
         n++;
      end
      check({15'h0, n < 600}, 16'h0001);
      exp_cnt++;
      @(negedge clock_i);
   endtask

   task automatic expect_out(input logic [1:0] m, input logic [11:0] c);
      check({4'h0, code}, {4'h0, c});
      check({14'h0, mode}, {14'h0, m});
      check({12'h0, amp_on, pd1k, pd100k, hiz}, {12'h0, m == 0, m == 1, m == 2, m == 3});
      check({8'h0, count}, {8'h0, exp_cnt});
   endtask

   task automatic frame(input logic [1:0] m, input logic [11:0] c);
      @(negedge clock_i);
      fork
         u_host.send({2'b11, m, c}, 16, 1'b0);
         wait_upd();
      join
      expect_out(m, c);
   endtask

   // --------------------------------------------------------------
   // scenarios
   // --------------------------------------------------------------
   task automatic t_reset();
      expect_out(2'h0, CODE_RST);
      check({15'h0, overrun}, 16'h0000);
   endtask

   task automatic t_modes();
      int m;
      for (m = 0; m < 4; m++) frame(m[1:0], 12'h801);
      frame(2'h0, 12'hfff);
      frame(2'h0, 12'h000);
   endtask

   task automatic t_abort();
      frame(2'h0, 12'h3c5);
      @(negedge clock_i);
      u_host.send(16'hffff, 15, 1'b0);
      expect_out(2'h0, 12'h3c5);
      check({15'h0, busy}, 16'h0000);
      frame(2'h1, 12'h0f0);
   endtask

   task automatic t_bytes();
      @(negedge clock_i);
      fork
         begin
            u_host.send(16'h2a00, 8, 1'b1);
            check({15'h0, busy}, 16'h0001);
            u_host.send(16'h5c00, 8, 1'b0);
         end
         wait_upd();
      join
      expect_out(2'h2, 12'ha5c);
   endtask

   task automatic t_stall();
      int i;
      @(posedge clock_i);
      conv_ready_i <= 1'b0;
      for (i = 1; i < 5; i++) begin
         @(negedge clock_i);
         u_host.send({4'h0, 8'h10, i[3:0]}, 16, 1'b0);
      end
      check({8'h0, count}, {8'h0, exp_cnt});
      check({15'h0, overrun}, 16'h0001);
      @(posedge clock_i);
      conv_ready_i <= 1'b1;
      repeat (3) wait_upd();
      expect_out(2'h0, 12'h104);
   endtask

   initial begin
      clock_i         = 1'b0;
      rst_n_i         = 1'b0;
      conv_ready_i    = 1'b1;
      exp_cnt         = 8'h00;
      failures        = 0;
      samples_checked = 0;
      cycles          = 0;
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(negedge clock_i);
      t_reset();
      t_modes();
      t_abort();
      t_bytes();
      t_stall();
      end_sim();
   end
endmodule
`default_nettype wire
